/* File: shared/line_timing_pkg.sv */
package line_timing_pkg;
  // Clock and line oscillator
  localparam int CLK_MHZ = 50;
  localparam int CLK_HZ = CLK_MHZ * 1000000;
  localparam int OSC_HZ = 500000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int DIV_STAGES = 5;
  localparam int LINE_OSC = 2 ** DIV_STAGES;
  localparam int LINE_CYC = LINE_OSC * OSC_DIV;
  localparam int POS_W = 12;
  // Times in ns, least times rounded up to clock cycles
  localparam int RESET_NS = 6500;
  localparam int REF_DELAY_NS = 2600;
  localparam int WINDOW_NS = 16000;
  localparam int PULSE_NS = 29000;
  localparam int COINC_NS = 2000;
  localparam int BLANK_NS = 12000;
  localparam int REF_NS = 2000;
  localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_DELAY_CYC = (REF_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int WINDOW_CYC = (WINDOW_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int COINC_CYC = (COINC_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_CYC = (REF_NS * CLK_MHZ + 999) / 1000;
  // Positions within the line, zero at the sawtooth falling edge
  localparam int SYNC_MID_POS = 200;
  localparam int COINC_POS = SYNC_MID_POS - COINC_CYC / 2;
  localparam int REF_POS = SYNC_MID_POS + REF_DELAY_CYC;
  // Frame lines free of line-trace gating
  localparam int LINE_NUM_W = 10;
  localparam logic [9:0] FREE_FIRST_LINE = 10'h008;
  localparam logic [9:0] FREE_LAST_LINE = 10'h015;
  // Register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] SYNCW_OFS = 4'h8;
  localparam int CTRL_SHORT_BIT = 0;
  localparam int CTRL_INHIBIT_BIT = 1;
  localparam int ST_VIDEO_BIT = 0;
  localparam int ST_DRIVE_BIT = 1;
  localparam int ST_PULSE_BIT = 2;
  localparam int ST_OSC_LSB = 8;
  localparam int ST_LINE_LSB = 16;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  typedef enum {DRV_IDLE, DRV_PULSE} drive_state_t;
endpackage : line_timing_pkg

/* File: logic/line_window.sv */
// Flags the line positions start .. start+len-1
module line_window #(
  parameter int START = 0,
  parameter int LEN = 1,
  parameter int W = 12
) (
  input wire logic [W-1:0] pos_i,
  output logic hit_o
);
  localparam logic [W-1:0] FIRST = W'(START);
  localparam logic [W-1:0] LAST = W'(START + LEN - 1);

  assign hit_o = (pos_i >= FIRST) && (pos_i <= LAST);
endmodule : line_window

/* File: logic/line_phase_inhibit_timing.sv */
// The Wishbone slave port and the placing of the registers were decided locally.
module line_phase_inhibit_timing #(
  parameter int RESET_CYC = line_timing_pkg::RESET_CYC,
  parameter int WINDOW_CYC = line_timing_pkg::WINDOW_CYC,
  parameter int PULSE_CYC = line_timing_pkg::PULSE_CYC,
  parameter int REF_DELAY_CYC = line_timing_pkg::REF_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_sync_i,
  input wire logic frame_retrace_inhibit_i,
  input wire logic extracted_frame_sync_i,
  input wire logic mod_edge_i,
  input wire logic mod_disable_i,
  input wire logic startup_inhibit_i,
  input wire logic flyback_i,
  input wire logic safety_inhibit_i,
  output logic comparator_gate_long_o,
  output logic comparator_gate_short_o,
  output logic sawtooth_reset_o,
  output logic phase_ref_o,
  output logic drive_o
);
  localparam int PW = line_timing_pkg::POS_W;
  localparam int LW = line_timing_pkg::LINE_NUM_W;
  localparam logic [PW-1:0] LINE_LAST = PW'(line_timing_pkg::LINE_CYC - 1);
  localparam logic [PW-1:0] LINE_LEN = PW'(line_timing_pkg::LINE_CYC);
  localparam logic [PW-1:0] MID_POS = PW'(line_timing_pkg::SYNC_MID_POS);
  localparam logic [PW-1:0] REF_AT = PW'(line_timing_pkg::SYNC_MID_POS
                                        + REF_DELAY_CYC);
  localparam logic [PW-1:0] WIN_LAST = PW'(WINDOW_CYC - 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);
  localparam logic [PW-1:0] OSC_DIV_W = PW'(line_timing_pkg::OSC_DIV);
  localparam logic [LW-1:0] LINE_MAX = '1;

  generate
    if (PULSE_CYC < 1 || PULSE_CYC >= line_timing_pkg::LINE_CYC ||
        WINDOW_CYC < 1 || WINDOW_CYC >= line_timing_pkg::LINE_CYC ||
        RESET_CYC < 1 || RESET_CYC >= line_timing_pkg::LINE_CYC ||
        line_timing_pkg::SYNC_MID_POS + REF_DELAY_CYC +
        line_timing_pkg::REF_CYC >= line_timing_pkg::LINE_CYC) begin : g_chk
      $error("line_phase_inhibit_timing: timing counts do not fit a line");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Line timebase, resynchronised at the middle of line sync
  logic [PW-1:0] pos_reg;
  logic [PW-1:0] pos_next;
  logic [PW-1:0] syncw_reg;
  logic [PW-1:0] syncw_last_reg;
  logic sync_prev_reg;
  logic [LW-1:0] line_num_reg;
  logic frame_sync_prev_reg;

  wire sync_rise = line_sync_i & ~sync_prev_reg;
  wire sync_fall = ~line_sync_i & sync_prev_reg;
  wire [PW:0] mid_sum = {1'b0, MID_POS} + {2'b00, syncw_reg[PW-1:1]};
  wire [PW-1:0] mid_load = (mid_sum >= {1'b0, LINE_LEN}) ?
                           PW'(mid_sum - {1'b0, LINE_LEN}) : mid_sum[PW-1:0];
  wire line_wrap = (pos_reg == LINE_LAST);
  wire frame_start = extracted_frame_sync_i & ~frame_sync_prev_reg;
  wire [4:0] osc_period = 5'(pos_reg / OSC_DIV_W);

  assign pos_next = sync_fall ? mid_load :
                    line_wrap ? '0 : pos_reg + 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= '0;
      syncw_reg <= '0;
      syncw_last_reg <= '0;
      sync_prev_reg <= 1'b0;
      frame_sync_prev_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      sync_prev_reg <= line_sync_i;
      frame_sync_prev_reg <= extracted_frame_sync_i;
      if (sync_rise) begin
        syncw_reg <= PW'(1);
      end else if (line_sync_i && syncw_reg != '1) begin
        syncw_reg <= syncw_reg + 1'b1;
      end
      if (sync_fall) begin
        syncw_last_reg <= syncw_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_num_reg <= '0;
    end else if (frame_start) begin
      line_num_reg <= '0;
    end else if (line_wrap && line_num_reg != LINE_MAX) begin
      line_num_reg <= line_num_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position windows
  logic saw_hit;
  logic coinc_hit;
  logic ref_hit;
  logic blank_hit;
  logic win_hit;

  line_window #(.START(0), .LEN(RESET_CYC), .W(PW)) u_saw (
    .pos_i(pos_reg), .hit_o(saw_hit));
  line_window #(.START(line_timing_pkg::COINC_POS),
    .LEN(line_timing_pkg::COINC_CYC), .W(PW)) u_coinc (
    .pos_i(pos_reg), .hit_o(coinc_hit));
  line_window #(.START(line_timing_pkg::SYNC_MID_POS + REF_DELAY_CYC),
    .LEN(line_timing_pkg::REF_CYC), .W(PW)) u_ref (
    .pos_i(pos_reg), .hit_o(ref_hit));
  line_window #(.START(0), .LEN(line_timing_pkg::BLANK_CYC), .W(PW)) u_blank (
    .pos_i(pos_reg), .hit_o(blank_hit));
  line_window #(.START(0), .LEN(WINDOW_CYC), .W(PW)) u_win (
    .pos_i(pos_reg), .hit_o(win_hit));

  ////////////////////////////////////////////////////////////////////////////
  // Video presence and comparator gating
  logic coinc_seen_reg;
  logic video_present_reg;
  logic ctrl_short_reg;
  logic ctrl_inhibit_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coinc_seen_reg <= 1'b0;
      video_present_reg <= 1'b0;
    end else if (line_wrap) begin
      video_present_reg <= coinc_seen_reg | (coinc_hit & line_sync_i);
      coinc_seen_reg <= 1'b0;
    end else if (coinc_hit && line_sync_i) begin
      coinc_seen_reg <= 1'b1;
    end
  end

  localparam logic [LW-1:0] FREE_FIRST = line_timing_pkg::FREE_FIRST_LINE;
  localparam logic [LW-1:0] FREE_LAST = line_timing_pkg::FREE_LAST_LINE;
  wire blanking_window = (line_num_reg >= FREE_FIRST) &&
                         (line_num_reg <= FREE_LAST);
  wire line_trace_gate = ~blank_hit;
  wire frame_gate = frame_retrace_inhibit_i | extracted_frame_sync_i;
  wire gate_long = video_present_reg &
                   (frame_gate | (~blanking_window & line_trace_gate));
  wire gate_frame = video_present_reg & frame_gate;
  wire gate_long_next = ctrl_short_reg ? gate_frame : gate_long;
  wire gate_short_next = ctrl_short_reg ? gate_frame : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Line drive flip-flop
  line_timing_pkg::drive_state_t drv_state_reg;
  line_timing_pkg::drive_state_t drv_state_next;
  logic [PW-1:0] drv_cnt_reg;
  logic fired_reg;
  logic mod_prev_reg;

  wire mod_rise = mod_edge_i & ~mod_prev_reg;
  wire set_req = ~fired_reg & win_hit &
                 (mod_rise | mod_disable_i | pos_reg == WIN_LAST);
  wire inhibit = startup_inhibit_i | flyback_i | safety_inhibit_i |
                 ctrl_inhibit_reg;

  always_comb begin
    drv_state_next = drv_state_reg;
    case (drv_state_reg)
      line_timing_pkg::DRV_IDLE: begin
        if (set_req) begin
          drv_state_next = line_timing_pkg::DRV_PULSE;
        end
      end
      line_timing_pkg::DRV_PULSE: begin
        if (drv_cnt_reg == PULSE_LAST) begin
          drv_state_next = line_timing_pkg::DRV_IDLE;
        end
      end
      default: drv_state_next = line_timing_pkg::DRV_IDLE;
    endcase
  end

  wire pulse_next = (drv_state_next == line_timing_pkg::DRV_PULSE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_state_reg <= line_timing_pkg::DRV_IDLE;
      drv_cnt_reg <= '0;
      fired_reg <= 1'b0;
      mod_prev_reg <= 1'b0;
    end else begin
      drv_state_reg <= drv_state_next;
      mod_prev_reg <= mod_edge_i;
      drv_cnt_reg <= (drv_state_reg == line_timing_pkg::DRV_PULSE) ?
                     drv_cnt_reg + 1'b1 : '0;
      if (line_wrap) begin
        fired_reg <= 1'b0;
      end else if (set_req) begin
        fired_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_gate_long_o <= 1'b0;
      comparator_gate_short_o <= 1'b0;
      sawtooth_reset_o <= 1'b0;
      phase_ref_o <= 1'b0;
      drive_o <= 1'b1;
    end else begin
      comparator_gate_long_o <= gate_long_next;
      comparator_gate_short_o <= gate_short_next;
      sawtooth_reset_o <= saw_hit;
      phase_ref_o <= ref_hit;
      drive_o <= inhibit | pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, answers one cycle after the request
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ctrl = req & wb_we_i & wb_sel_i[0] &
                 (wb_adr_i == line_timing_pkg::CTRL_OFS);
  wire [31:0] ctrl_word = {30'h0, ctrl_inhibit_reg, ctrl_short_reg};
  wire [31:0] status_word = {6'h0, line_num_reg, 3'h0, osc_period, 5'h0,
                             drv_state_reg == line_timing_pkg::DRV_PULSE,
                             drive_o, video_present_reg};
  wire [31:0] rd_word = (wb_adr_i == line_timing_pkg::CTRL_OFS) ? ctrl_word :
                        (wb_adr_i == line_timing_pkg::STATUS_OFS) ?
                        status_word :
                        (wb_adr_i == line_timing_pkg::SYNCW_OFS) ?
                        {20'h0, syncw_last_reg} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_short_reg <= line_timing_pkg::CTRL_RESET[0];
      ctrl_inhibit_reg <= line_timing_pkg::CTRL_RESET[1];
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_word : 32'h0;
      if (wr_ctrl) begin
        ctrl_short_reg <= wb_dat_i[line_timing_pkg::CTRL_SHORT_BIT];
        ctrl_inhibit_reg <= wb_dat_i[line_timing_pkg::CTRL_INHIBIT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [PW-1:0] saw_run_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !sawtooth_reset_o) begin
      saw_run_reg <= '0;
    end else begin
      saw_run_reg <= saw_run_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_long_short_one;
    !ctrl_short_reg |=> comparator_gate_short_o;
  endproperty
  a_long_short_one: assert property (p_long_short_one)
    else $error("short gate not held high in long mode");

  property p_short_no_video;
    ctrl_short_reg && !video_present_reg |=>
      !comparator_gate_long_o && !comparator_gate_short_o;
  endproperty
  a_short_no_video: assert property (p_short_no_video)
    else $error("gate open without video in short mode");

  property p_free_lines;
    blanking_window && !frame_gate |=> !comparator_gate_long_o;
  endproperty
  a_free_lines: assert property (p_free_lines)
    else $error("trace gating applied in lines 8 to 21");

  property p_frame_sync;
    video_present_reg && extracted_frame_sync_i |=>
      comparator_gate_long_o && comparator_gate_short_o;
  endproperty
  a_frame_sync: assert property (p_frame_sync)
    else $error("frame sync did not gate the comparator");

  property p_saw_len;
    $fell(sawtooth_reset_o) |-> $past(saw_run_reg) <= PW'(RESET_CYC - 1);
  endproperty
  a_saw_len: assert property (p_saw_len)
    else $error("sawtooth reset too long");

  property p_ref_place;
    pos_reg == REF_AT && !sync_fall |=> phase_ref_o ##1 phase_ref_o;
  endproperty
  a_ref_place: assert property (p_ref_place)
    else $error("phase reference misplaced");

  // Pulse too long for a plain delay, so its cycles are counted
  logic [PW-1:0] pulse_run_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || drv_state_reg != line_timing_pkg::DRV_PULSE) begin
      pulse_run_reg <= '0;
    end else begin
      pulse_run_reg <= pulse_run_reg + 1'b1;
    end
  end

  property p_pulse_width;
    $fell(drv_state_reg == line_timing_pkg::DRV_PULSE) |->
      $past(pulse_run_reg) == PW'(PULSE_CYC - 1);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("drive pulse width wrong");

  property p_window_end;
    pos_reg == WIN_LAST && !sync_fall |=> fired_reg;
  endproperty
  a_window_end: assert property (p_window_end)
    else $error("no drive set by window end");

  property p_auto_set;
    mod_disable_i && win_hit && !fired_reg &&
      drv_state_reg == line_timing_pkg::DRV_IDLE |=>
      drv_state_reg == line_timing_pkg::DRV_PULSE ##1 drive_o;
  endproperty
  a_auto_set: assert property (p_auto_set)
    else $error("disabled modulator did not force set");

  property p_inhibit;
    startup_inhibit_i || flyback_i || safety_inhibit_i |=> drive_o;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("drive not held high under inhibit");

  property p_video;
    line_wrap && coinc_seen_reg |=> video_present_reg;
  endproperty
  a_video: assert property (p_video)
    else $error("coincidence did not set video flag");

  property p_reset;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> drive_o && !wb_ack_o &&
      drv_state_reg == line_timing_pkg::DRV_IDLE;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not idle the block");

  c_mod_set: cover property (mod_rise && win_hit && !fired_reg);
  c_fallback: cover property (pos_reg == WIN_LAST && !fired_reg);
  c_short_gate: cover property (ctrl_short_reg && comparator_gate_long_o);
  c_free_line: cover property (blanking_window && video_present_reg);
endmodule : line_phase_inhibit_timing

/* File: bench/line_far_side_model.sv */
module line_far_side_model #(
  parameter int LINE_CYC = 3200,
  parameter int FRAME_LINES = 26,
  parameter int START_LINE = 22,
  parameter int STORE_CYC = 200,
  parameter int FLY_CYC = 600
) (
  input wire logic clk_i,
  input wire logic sync_en_i,
  input wire logic drive_i,
  input wire logic fly_force_i,
  output logic line_sync_o,
  output logic frame_sync_o,
  output logic flyback_o,
  output logic [11:0] pos_o,
  output logic [9:0] line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] pos_reg = 12'h000;
  logic [9:0] line_reg = 10'(START_LINE);
  logic drive_d = 1'b1;
  int fly_cnt = 0;
  //////////////////////////////////////////////////////////////////////
  // Free running line and frame count of the video source
  always @(posedge clk_i) begin
    if (pos_reg == 12'(LINE_CYC - 1)) begin
      pos_reg <= 12'h000;
      if (line_reg == 10'(FRAME_LINES - 1)) begin
        line_reg <= 10'h000;
      end else begin
        line_reg <= line_reg + 10'h001;
      end
    end else begin
      pos_reg <= pos_reg + 12'h001;
    end
    drive_d <= drive_i;
    // Flyback follows transistor turn-off after storage time
    if (drive_i && !drive_d) begin
      fly_cnt <= 1;
    end else if (fly_cnt != 0 && fly_cnt < STORE_CYC + FLY_CYC) begin
      fly_cnt <= fly_cnt + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  assign pos_o = pos_reg;
  assign line_o = line_reg;
  // Sync pulse centred on position 200
  assign line_sync_o = sync_en_i && pos_reg >= 12'h096 && pos_reg < 12'h0fa;
  assign frame_sync_o = line_reg < 10'h003;
  assign flyback_o = fly_force_i ||
    (fly_cnt >= STORE_CYC && fly_cnt < STORE_CYC + FLY_CYC);
endmodule : line_far_side_model

/* File: bench/tb_line_phase_inhibit_timing.sv */
module tb_line_phase_inhibit_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0] wb_adr, wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic retrace, mod_edge, mod_dis, startup, safety, sync_en, fly_force;
  logic line_sync, frame_sync, flyback, gate_long, gate_short, saw, pref;
  logic drive;
  logic [11:0] pos;
  logic [9:0] ln;
  logic [2:0] watched;
  logic [2:0] w_d = 3'h0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int rise_at[3], width[3], run[3], period[3], last_cyc[3];

  line_phase_inhibit_timing u_line_phase_inhibit_timing (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .line_sync_i(line_sync), .frame_retrace_inhibit_i(retrace),
    .extracted_frame_sync_i(frame_sync), .mod_edge_i(mod_edge),
    .mod_disable_i(mod_dis), .startup_inhibit_i(startup),
    .flyback_i(flyback), .safety_inhibit_i(safety),
    .comparator_gate_long_o(gate_long), .comparator_gate_short_o(gate_short),
    .sawtooth_reset_o(saw), .phase_ref_o(pref), .drive_o(drive));

  line_far_side_model u_line_far_side_model (
    .clk_i(clk_i), .sync_en_i(sync_en), .drive_i(drive),
    .fly_force_i(fly_force), .line_sync_o(line_sync),
    .frame_sync_o(frame_sync),
    .flyback_o(flyback), .pos_o(pos), .line_o(ln));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////
  // Rise position, high length and period of sawtooth, reference, drive
  assign watched = {drive, pref, saw};
  always @(posedge clk_i) begin
    cyc++;
    for (int i = 0; i < 3; i++) begin
      if (watched[i] && !w_d[i]) begin
        rise_at[i] = int'(pos);
        period[i] = cyc - last_cyc[i];
        last_cyc[i] = cyc;
        run[i] = 1;
      end else if (watched[i]) begin
        run[i]++;
      end else if (w_d[i]) begin
        width[i] = run[i];
      end
    end
    w_d = watched;
  end
  //////////////////////////////////////////////////////////////////////
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task check_eq(input string what, input logic [31:0] exp,
                input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_eq

  task check_near(input string what, input int exp, input int got);
    n_compared++;
    if (got < exp - 3 || got > exp + 3) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_near

  task check_gates(input logic l, input logic s);
    check_eq("long gate", {31'h0, l}, {31'h0, gate_long});
    check_eq("short gate", {31'h0, s}, {31'h0, gate_short});
  endtask : check_gates

  task wb(input logic we, input logic [3:0] a, input logic [3:0] s,
          input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task wait_at(input int l, input int p);
    do @(posedge clk_i);
    while (!(ln == 10'(l) && pos == 12'(p)));
  endtask : wait_at

  task set_inh(input int k, input logic v);
    case (k)
      0: startup <= v;
      1: safety <= v;
      2: fly_force <= v;
      default: wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, {30'h0, v, 1'b0});
    endcase
  endtask : set_inh
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    results();
  end

  initial begin
    {rst_i, sync_en} = 2'h3;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
    {retrace, mod_edge, mod_dis, startup, safety, fly_force} = '0;
    repeat (10) @(posedge clk_i);
    check_eq("drive in reset", 32'h1, {31'h0, drive});
    check_gates(1'b0, 1'b0);
    check_eq("reset outputs", 32'h0, {29'h0, saw, pref, wb_ack});
    rst_i <= 1'b0;
    wb(1'b0, line_timing_pkg::CTRL_OFS, 4'hf, 32'h0);
    check_eq("ctrl reset", 32'h0, rd);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h1);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'h0, 32'h0);
    wb(1'b0, line_timing_pkg::CTRL_OFS, 4'hf, 32'h0);
    check_eq("ctrl", 32'h1, rd);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h0);
    wb(1'b0, 4'hc, 4'hf, 32'h0);
    check_eq("unmapped", 32'h0, rd);
    wait_at(23, 3000);
    check_eq("reset width", line_timing_pkg::RESET_CYC, width[0]);
    check_near("ref rise", line_timing_pkg::REF_POS, rise_at[1]);
    check_eq("ref width", line_timing_pkg::REF_CYC, width[1]);
    check_near("window set", line_timing_pkg::WINDOW_CYC, rise_at[2]);
    check_eq("pulse width", line_timing_pkg::PULSE_CYC, width[2]);
    wb(1'b0, line_timing_pkg::STATUS_OFS, 4'hf, 32'h0);
    check_eq("video", 32'h1, {29'h0, rd[2:0]});
    check_eq("osc period", 32'h1e, {27'h0, rd[12:8]});
    wb(1'b0, line_timing_pkg::SYNCW_OFS, 4'hf, 32'h0);
    check_eq("sync width", 32'h64, rd);
    wait_at(24, 400);
    mod_edge <= 1'b1;
    wait_at(24, 410);
    mod_edge <= 1'b0;
    wait_at(24, 3000);
    check_eq("line period", 32 * line_timing_pkg::OSC_DIV, period[0]);
    check_near("edge set", 401, rise_at[2]);
    check_eq("edge width", line_timing_pkg::PULSE_CYC, width[2]);
    wait_at(25, 400);
    mod_dis <= 1'b1;
    wait_at(25, 410);
    mod_dis <= 1'b0;
    wait_at(25, 3000);
    check_near("auto set", 401, rise_at[2]);
    wait_at(1, 1600);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h1);
    repeat (3) @(posedge clk_i);
    check_gates(1'b1, 1'b1);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h0);
    wait_at(1, 2400);
    for (int k = 0; k < 4; k++) begin
      set_inh(k, 1'b1);
      repeat (3) @(posedge clk_i);
      check_eq("inhibited drive", 32'h1, {31'h0, drive});
      set_inh(k, 1'b0);
      repeat (3) @(posedge clk_i);
      check_eq("free drive", 32'h0, {31'h0, drive});
    end
    wait_at(4, 300);
    check_gates(1'b0, 1'b1);
    wait_at(4, 1600);
    check_gates(1'b1, 1'b1);
    wait_at(5, 1600);
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h1);
    repeat (3) @(posedge clk_i);
    check_gates(1'b0, 1'b0);
    retrace <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_gates(1'b1, 1'b1);
    retrace <= 1'b0;
    wb(1'b1, line_timing_pkg::CTRL_OFS, 4'hf, 32'h0);
    wait_at(14, 1600);
    check_gates(1'b0, 1'b1);
    retrace <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_gates(1'b1, 1'b1);
    retrace <= 1'b0;
    // No sync in line 24, so the flag drops at the next wrap
    wait_at(24, 100);
    sync_en <= 1'b0;
    wait_at(24, 1600);
    check_gates(1'b1, 1'b1);
    wait_at(25, 1600);
    wb(1'b0, line_timing_pkg::STATUS_OFS, 4'hf, 32'h0);
    check_eq("no video", 32'h0, {31'h0, rd[0]});
    retrace <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_gates(1'b0, 1'b1);
    results();
  end
endmodule : tb_line_phase_inhibit_timing
